//--- core/srm_consts.vh
// constants for the service request status and mask block
//
// Behaviour
// - eight-bit status, each condition sets its bit
// - measurement done sets status bit zero
// - any of six failures sets bit four
// - request only for enabled mask bits
// - mask matches status layout, no bit six
// - mask command sets bits 0-4 and 7
// - mask bit five follows switch only
// - status and mask match sets bit six
// - power-on with switch sets bit five
// - panel key sets bit seven, lights indicator when mask bit seven set
// - request on dedicated line, independent of bus
// - poll returns current status byte
// - poll clears status except retained causes
// - poll leaves mask unchanged
// - trigger/illegal causes clear, others retained
// - data ready retained when storage on
// - instrument clear keeps bit five
`ifndef SRM_CONSTS_VH
`define SRM_CONSTS_VH
`define SRM_BIT_READY   0
`define SRM_BIT_DIGINT  1
`define SRM_BIT_ALARM   2
`define SRM_BIT_TIMER   3
`define SRM_BIT_NOTEXEC 4
`define SRM_BIT_PON     5
`define SRM_BIT_SRQ     6
`define SRM_BIT_MANUAL  7
`define SRM_MASK_CMD    8'h9F
`define SRM_ZERO8       8'h00
`define SRM_NCAUSE      6
`define SRM_CLR_CAUSES  6'h05
`endif

//--- core/srm_status_bit.v
// one sticky status bit with separate clearable and retained causes
`timescale 1ns/1ns
`default_nettype none
module srm_status_bit (
  // clock and reset
  input  wire clk,
  input  wire arst_n,
  // causes
  input  wire set_clr,
  input  wire set_keep,
  input  wire poll_clr,
  input  wire inst_clr,
  // state
  output reg  bit_q
);
  reg keep_q;
  // set wins over a same-cycle clear
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_q  <= 1'b0;
      keep_q <= 1'b0;
    end else begin
      bit_q  <= set_clr | set_keep | (bit_q & ~inst_clr & ~(poll_clr & ~keep_q));
      keep_q <= set_keep | (keep_q & ~inst_clr);
    end
  end
endmodule
`default_nettype wire

//--- core/srm_top.v
// service request status register, mask and request line
`timescale 1ns/1ns
`default_nettype none
`include "srm_consts.vh"
module srm_top (
  // clock and reset
  input  wire       MCLK,
  input  wire       ARST_N,
  // condition pulses
  input  wire       MEAS_DONE,
  input  wire       STORAGE_ON,
  input  wire       NOTEXEC_TRIG,
  input  wire       NOTEXEC_OVERLAP,
  input  wire       NOTEXEC_ILLEGAL,
  input  wire       NOTEXEC_RANGE,
  input  wire       NOTEXEC_FULL,
  input  wire       NOTEXEC_NOSLOT,
  input  wire       TIMER_PULSE,
  input  wire       ALARM_PULSE,
  input  wire       DIGINT_PULSE,
  input  wire       PANEL_KEY_REQUEST,
  // configuration
  input  wire       POWERON_REQUEST_SWITCH,
  input  wire       MASK_SET_COMMAND,
  input  wire [7:0] MASK_SET_VALUE,
  input  wire       INSTRUMENT_CLEAR,
  // serial poll
  input  wire       SERIAL_POLL,
  output reg  [7:0] STATUS_BYTE,
  output reg        STATUS_VALID,
  // request line, indicator and mask readback
  output reg        SRQ_OUT,
  output reg        SRQ_OE,
  output reg        REQUEST_LED,
  output reg  [7:0] MASK_VIEW
);
  // ============================================================
  // power-on sampling of the switch after reset release
  reg        pon_done_q;
  reg        pon_set_d;
  reg  [7:0] mask_q;
  wire [7:0] status;
  wire [7:0] effective_mask;
  wire [5:0] ne_cause;
  wire       ne_clr_set;
  wire       ne_keep_set;
  wire       srq_now;
  wire [7:0] set_clr;
  wire [7:0] set_keep;
  wire [7:0] inst_clr;

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N)
      pon_done_q <= 1'b0;
    else
      pon_done_q <= 1'b1;
  end

  always @* begin
    pon_set_d = ~pon_done_q & POWERON_REQUEST_SWITCH;
  end

  // ============================================================
  // mask register
  // bit five comes from the switch, bit six never exists
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N)
      mask_q <= `SRM_ZERO8;
    else if (INSTRUMENT_CLEAR)
      mask_q <= `SRM_ZERO8;
    else if (MASK_SET_COMMAND)
      mask_q <= MASK_SET_VALUE & `SRM_MASK_CMD;
  end

  assign effective_mask = {mask_q[`SRM_BIT_MANUAL], 1'b0, POWERON_REQUEST_SWITCH,
                           mask_q[`SRM_BIT_NOTEXEC:`SRM_BIT_READY]};

  // ============================================================
  // cause decode
  // the six failures fold into one bit; which cause is lost
  assign ne_cause    = {NOTEXEC_NOSLOT, NOTEXEC_FULL, NOTEXEC_RANGE,
                        NOTEXEC_ILLEGAL, NOTEXEC_OVERLAP, NOTEXEC_TRIG};
  assign ne_clr_set  = |(ne_cause & `SRM_CLR_CAUSES);
  assign ne_keep_set = |(ne_cause & ~`SRM_CLR_CAUSES);

  assign set_clr[`SRM_BIT_READY]    = MEAS_DONE & ~STORAGE_ON;
  assign set_keep[`SRM_BIT_READY]   = MEAS_DONE & STORAGE_ON;
  assign set_clr[`SRM_BIT_DIGINT]   = DIGINT_PULSE;
  assign set_keep[`SRM_BIT_DIGINT]  = 1'b0;
  assign set_clr[`SRM_BIT_ALARM]    = ALARM_PULSE;
  assign set_keep[`SRM_BIT_ALARM]   = 1'b0;
  assign set_clr[`SRM_BIT_TIMER]    = TIMER_PULSE;
  assign set_keep[`SRM_BIT_TIMER]   = 1'b0;
  assign set_clr[`SRM_BIT_NOTEXEC]  = ne_clr_set;
  assign set_keep[`SRM_BIT_NOTEXEC] = ne_keep_set;
  assign set_clr[`SRM_BIT_PON]      = pon_set_d;
  assign set_keep[`SRM_BIT_PON]     = 1'b0;
  assign set_clr[`SRM_BIT_MANUAL]   = PANEL_KEY_REQUEST;
  assign set_keep[`SRM_BIT_MANUAL]  = 1'b0;
  // summary bit is recomputed every cycle from the others
  assign srq_now = |(status & effective_mask & `SRM_MASK_CMD) |
                   (status[`SRM_BIT_PON] & effective_mask[`SRM_BIT_PON]);
  assign set_clr[`SRM_BIT_SRQ]      = srq_now;
  assign set_keep[`SRM_BIT_SRQ]     = 1'b0;

  // ============================================================
  // status bits
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
      // summary bit never holds: its hold path is always cut, so it follows srq_now one cycle late
      assign inst_clr[gi] = (INSTRUMENT_CLEAR & (gi != `SRM_BIT_PON)) | (gi == `SRM_BIT_SRQ);
      srm_status_bit u_bit (
        .clk      (MCLK),
        .arst_n   (ARST_N),
        .set_clr  (set_clr[gi]),
        .set_keep (set_keep[gi]),
        .poll_clr (SERIAL_POLL),
        .inst_clr (inst_clr[gi]),
        .bit_q    (status[gi])
      );
    end
  endgenerate

  // ============================================================
  // outputs
  // poll byte is the register before this cycle's clear
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N)
      STATUS_BYTE <= `SRM_ZERO8;
    else if (SERIAL_POLL)
      STATUS_BYTE <= status;
  end

  // one-cycle strobe: the byte stands until the next poll
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N)
      STATUS_VALID <= 1'b0;
    else
      STATUS_VALID <= SERIAL_POLL;
  end

  // ============================================================
  // request line, driven only while requesting
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N)
      SRQ_OUT <= 1'b0;
    else
      SRQ_OUT <= status[`SRM_BIT_SRQ];
  end

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N)
      SRQ_OE <= 1'b0;
    else
      SRQ_OE <= status[`SRM_BIT_SRQ];
  end

  // ============================================================
  // indicator and mask readback
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N)
      REQUEST_LED <= 1'b0;
    else
      REQUEST_LED <= status[`SRM_BIT_MANUAL] & effective_mask[`SRM_BIT_MANUAL];
  end

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N)
      MASK_VIEW <= `SRM_ZERO8;
    else
      MASK_VIEW <= effective_mask;
  end
endmodule
`default_nettype wire

//--- dv/srm_props.sv
// checker for the service request status and mask block
`timescale 1ns/1ns
`default_nettype none
module srm_props (
  input wire logic       MCLK, ARST_N, PANEL_KEY_REQUEST, MASK_SET_COMMAND, INSTRUMENT_CLEAR, SERIAL_POLL,
  input wire logic [7:0] MASK_SET_VALUE, STATUS_BYTE, MASK_VIEW,
  input wire logic       STATUS_VALID, SRQ_OUT, SRQ_OE, REQUEST_LED
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  sequence key_in;
    PANEL_KEY_REQUEST && MASK_VIEW[7] && !INSTRUMENT_CLEAR;
  endsequence
  sequence calm3;
    (!SERIAL_POLL && !INSTRUMENT_CLEAR && !MASK_SET_COMMAND) [*3];
  endsequence
  six_clear_a: assert property (!MASK_VIEW[6]) else $error("mask bit six set");
  mask_cmd_a: assert property (MASK_SET_COMMAND && !INSTRUMENT_CLEAR |->
    ##[1:2] (MASK_VIEW & 8'h9F) == (MASK_SET_VALUE & 8'h9F)) else $error("mask not loaded");
  pon_keep_a: assert property (MASK_SET_COMMAND |=> $stable(MASK_VIEW[5])) else $error("bit five moved");
  poll_ans_a: assert property (SERIAL_POLL |=> STATUS_VALID) else $error("no poll answer");
  valid_src_a: assert property (STATUS_VALID |-> $past(SERIAL_POLL)) else $error("stray valid");
  oe_match_a: assert property (SRQ_OE == SRQ_OUT) else $error("enable differs");
  key_srq_a: assert property (key_in ##1 calm3 |-> SRQ_OUT) else $error("no request");
  led_mask_a: assert property (REQUEST_LED |-> MASK_VIEW[7] || $past(MASK_VIEW[7])) else $error("led lit");
endmodule
bind srm_top srm_props i_srm_props (.MCLK(MCLK), .ARST_N(ARST_N), .PANEL_KEY_REQUEST(PANEL_KEY_REQUEST),
  .MASK_SET_COMMAND(MASK_SET_COMMAND), .INSTRUMENT_CLEAR(INSTRUMENT_CLEAR), .SERIAL_POLL(SERIAL_POLL),
  .MASK_SET_VALUE(MASK_SET_VALUE), .STATUS_BYTE(STATUS_BYTE), .MASK_VIEW(MASK_VIEW),
  .STATUS_VALID(STATUS_VALID), .SRQ_OUT(SRQ_OUT), .SRQ_OE(SRQ_OE), .REQUEST_LED(REQUEST_LED));
`default_nettype wire

//--- dv/srm_ctl_model.sv
// bus controller model that answers a request with a serial poll
`timescale 1ns/1ns
`default_nettype none
module srm_ctl_model (
  input  wire logic       clk, arst_n, srq, auto_en, manual,
  input  wire logic [3:0] delay,
  output logic            poll
);
  logic [3:0] cnt_q;
  logic       fire_q;
  logic       go;
  assign go = auto_en && srq && !fire_q;
  assign poll = manual | fire_q;
  // delay of 2 or more, since the request line lags the poll by two cycles
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= 4'h0;
      fire_q <= 1'b0;
    end else begin
      fire_q <= go && cnt_q == delay;
      cnt_q  <= (go && cnt_q != delay) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

//--- dv/service_request_status_mask_bench.sv
// self-checking bench for the service request status and mask block
`timescale 1ns/1ns
`default_nettype none
module service_request_status_mask_bench;
  logic        mclk = 1'b0, arst_n = 1'b0, sw = 1'b0, mcmd = 1'b0, iclr = 1'b0, man = 1'b0, auto_en = 1'b0;
  logic [11:0] src = 12'h000;
  logic [7:0]  mval = 8'h00;
  logic [3:0]  dly = 4'h3;
  wire logic   poll, srq, oe, led, vld;
  wire logic [7:0] sbyte, mview;
  int          error_cnt = 0, n_tests = 0;
  // sources (bit 11 is storage on), mask, first and second poll bytes
  logic [35:0] rows [15] = '{36'h001000100, 36'h801000101, 36'h002001000, 36'h004001010, 36'h008001000,
    36'h010001010, 36'h020001010, 36'h040001010, 36'h080000800, 36'h100000400, 36'h200000200,
    36'h400008000, 36'h400FFC000, 36'h080084800, 36'h004105050};
  srm_top i_srm_top (.MCLK(mclk), .ARST_N(arst_n), .MEAS_DONE(src[0]), .STORAGE_ON(src[11]),
    .NOTEXEC_TRIG(src[1]), .NOTEXEC_OVERLAP(src[2]), .NOTEXEC_ILLEGAL(src[3]), .NOTEXEC_RANGE(src[4]),
    .NOTEXEC_FULL(src[5]), .NOTEXEC_NOSLOT(src[6]), .TIMER_PULSE(src[7]), .ALARM_PULSE(src[8]),
    .DIGINT_PULSE(src[9]), .PANEL_KEY_REQUEST(src[10]), .POWERON_REQUEST_SWITCH(sw),
    .MASK_SET_COMMAND(mcmd), .MASK_SET_VALUE(mval), .INSTRUMENT_CLEAR(iclr), .SERIAL_POLL(poll),
    .STATUS_BYTE(sbyte), .STATUS_VALID(vld), .SRQ_OUT(srq), .SRQ_OE(oe), .REQUEST_LED(led), .MASK_VIEW(mview));
  srm_ctl_model i_srm_ctl_model (.clk(mclk), .arst_n(arst_n), .srq(srq), .auto_en(auto_en),
    .manual(man), .delay(dly), .poll(poll));
  initial begin
    forever #10 mclk = ~mclk;
  end
  task tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task set_mask(input logic [7:0] v);
    mval = v;
    mcmd = 1'b1;
    tick();
    mcmd = 1'b0;
    tick(2);
  endtask
  task do_poll(input logic [7:0] exp);
    man = 1'b1;
    tick();
    man = 1'b0;
    chk({7'h00, vld}, 8'h01);
    chk(sbyte, exp);
    tick(3);
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    int w;
    tick(8);
    arst_n = 1'b1;
    tick(2);
    foreach (rows[i]) begin
      iclr = 1'b1;
      tick();
      iclr = 1'b0;
      set_mask(rows[i][23:16]);
      src = rows[i][35:24];
      tick();
      src = {src[11], 11'h000};
      tick(3);
      do_poll(rows[i][15:8]);
      do_poll(rows[i][7:0]);
      src = 12'h000;
    end
    $display("table of sources done");
    sw = 1'b1;
    arst_n = 1'b0;
    tick(2);
    arst_n = 1'b1;
    tick(4);
    chk(mview, 8'h20);
    chk({7'h00, srq}, 8'h01);
    set_mask(8'hFF);
    chk(mview, 8'hBF);
    iclr = 1'b1;
    tick();
    iclr = 1'b0;
    tick(3);
    do_poll(8'h60);
    do_poll(8'h00);
    $display("power-on request done");
    auto_en = 1'b1;
    for (int k = 0; k < 2; k++) begin
      dly = 4'(3 + 6 * k);
      set_mask(8'h80);
      src = 12'h400;
      tick();
      src = 12'h000;
      tick();
      chk({7'h00, led}, 8'h01);
      for (w = 0; w < 40 && vld !== 1'b1; w++) tick();
      if (w == 40) begin
        error_cnt++;
        close_out();
      end
      chk(sbyte, 8'hC0);
      tick(3);
      chk({7'h00, srq}, 8'h00);
    end
    $display("controller poll done");
    close_out();
  end
endmodule
`default_nettype wire
